/* vicb_pkg.sv */
// Behaviour
// - pending while enabled and hardware or software request
// - raw status shows synchronized (two-flop delayed) unmasked input levels
// - absent input bit positions read zero, ignore writes
// - software request ORed with input, then enabled
// - set alias sets software bits, reads zero
// - clear alias clears software bits, reads zero
// - handler address shows winner, zero when idle
// - chained winner passes upstream handler address through
// - local handler is index times size plus base
// - configuration bits 5:0 hold requested level
// - configuration bit 6 selects non-maskable behaviour
// - configuration bits 12:7 hold register set number
// - vector entry size is four shifted by field
// - global configuration bit 3 enables chained input if built
// - chain enable reads one only when chain exists
// - status holds winner number and outstanding flag
package vicb_pkg;
  localparam int NUM_SLOTS = 32;
  localparam int ADDR_W = 6;
  localparam logic [5:0] CHAIN_INDEX = 6'h20;

  // word indices on the register port
  localparam logic [5:0] OFS_CFG_LAST = 6'h1f;
  localparam logic [5:0] OFS_RAW_STATUS = 6'h24;
  localparam logic [5:0] OFS_SW_REQUEST = 6'h25;
  localparam logic [5:0] OFS_SW_SET = 6'h26;
  localparam logic [5:0] OFS_SW_CLEAR = 6'h27;
  localparam logic [5:0] OFS_GLOBAL_CFG = 6'h28;
  localparam logic [5:0] OFS_GLOBAL_STATUS = 6'h29;
  localparam logic [5:0] OFS_VEC_BASE = 6'h2a;
  localparam logic [5:0] OFS_HANDLER = 6'h2b;

  // per-input configuration fields
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_W = 6;
  localparam int NMI_BIT = 6;
  localparam int REGSET_LSB = 7;
  localparam int REGSET_W = 6;
  localparam int CFG_W = 13;

  // global configuration and status fields
  localparam int SIZE_LSB = 0;
  localparam int SIZE_W = 3;
  localparam int CHAIN_EN_BIT = 3;
  localparam int WIN_LSB = 0;
  localparam int WIN_W = 6;
  localparam int OUTSTANDING_BIT = 31;
  localparam int ENTRY_SHIFT_BASE = 2;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [CFG_W-1:0] RESET_CFG = 13'h0000;
  localparam logic [SIZE_W:0] RESET_GCFG = 4'h0;

  typedef logic [CFG_W-1:0] vicb_cfg_t;
endpackage

/* vicb_top.sv */
`timescale 1ns/1ps
module vicb_top #(
  parameter int NUM_INPUTS = 8,
  parameter bit CHAIN_PRESENT = 1'b0
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [5:0] CSR_ADDRESS,
  input wire logic CSR_WRITE,
  input wire logic CSR_READ,
  input wire logic [31:0] CSR_WRITEDATA,
  output logic [31:0] CSR_READDATA,
  input wire logic [31:0] IRQ,
  input wire logic [31:0] ENABLE,
  input wire logic CHAIN_VALID,
  input wire logic [5:0] CHAIN_LEVEL,
  input wire logic CHAIN_NMI,
  input wire logic [5:0] CHAIN_REGSET,
  input wire logic [31:0] CHAIN_HANDLER,
  output logic [31:0] PENDING,
  output logic OUT_VALID,
  output logic [5:0] OUT_LEVEL,
  output logic OUT_NMI,
  output logic [5:0] OUT_REGSET,
  output logic [31:0] OUT_HANDLER
);
  logic [31:0] present;
  logic [31:0] irq_meta_reg;
  logic [31:0] irq_sync_reg;
  logic [31:0] sw_req_reg, sw_req_next;
  logic [31:0] pend_reg, pend_next;
  vicb_pkg::vicb_cfg_t cfg_reg [vicb_pkg::NUM_SLOTS];
  vicb_pkg::vicb_cfg_t cfg_next [vicb_pkg::NUM_SLOTS];
  logic [vicb_pkg::SIZE_W:0] gcfg_reg, gcfg_next;
  logic [31:0] base_reg, base_next;
  logic [31:0] rdata_reg, rdata_next;
  logic valid_reg, valid_next;
  logic [5:0] win_reg, win_next;
  logic [5:0] level_reg, level_next;
  logic nmi_reg, nmi_next;
  logic [5:0] regset_reg, regset_next;
  logic [31:0] handler_reg, handler_next;
  logic chain_on;

  genvar g;
  generate
    for (g = 0; g < vicb_pkg::NUM_SLOTS; g++) begin : g_present
      assign present[g] = (g < NUM_INPUTS);
    end
  endgenerate

  // chain usable only when built in
  assign chain_on = CHAIN_PRESENT && gcfg_reg[vicb_pkg::CHAIN_EN_BIT];

  // request pins come from other logic domains
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      irq_meta_reg <= vicb_pkg::RESET_WORD;
      irq_sync_reg <= vicb_pkg::RESET_WORD;
    end else begin
      irq_meta_reg <= IRQ;
      irq_sync_reg <= irq_meta_reg;
    end
  end

  // register writes
  always_comb begin
    sw_req_next = sw_req_reg;
    gcfg_next = gcfg_reg;
    base_next = base_reg;
    for (int i = 0; i < vicb_pkg::NUM_SLOTS; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    if (CSR_WRITE) begin
      if (CSR_ADDRESS <= vicb_pkg::OFS_CFG_LAST) begin
        if (present[CSR_ADDRESS[4:0]]) begin
          cfg_next[CSR_ADDRESS[4:0]] = CSR_WRITEDATA[vicb_pkg::CFG_W-1:0];
        end
      end
      unique case (CSR_ADDRESS)
        vicb_pkg::OFS_SW_REQUEST: sw_req_next = CSR_WRITEDATA & present;
        vicb_pkg::OFS_SW_SET: sw_req_next = sw_req_reg | (CSR_WRITEDATA & present);
        vicb_pkg::OFS_SW_CLEAR: sw_req_next = sw_req_reg & ~CSR_WRITEDATA;
        vicb_pkg::OFS_GLOBAL_CFG: begin
          // size field stored; chain bit kept only if built
          gcfg_next[vicb_pkg::SIZE_W-1:0] = CSR_WRITEDATA[vicb_pkg::SIZE_W-1:0];
          gcfg_next[vicb_pkg::CHAIN_EN_BIT] =
            CSR_WRITEDATA[vicb_pkg::CHAIN_EN_BIT] & CHAIN_PRESENT;
        end
        // alignment left to software, stored as written
        vicb_pkg::OFS_VEC_BASE: base_next = CSR_WRITEDATA;
        default: begin
        end
      endcase
    end
  end

  // pending follows enable and request; OR then gate
  always_comb begin
    pend_next = (irq_sync_reg | sw_req_reg) & ENABLE & present;
  end

  // arbitration: highest level wins, lower index on a tie
  always_comb begin
    logic found;
    logic [5:0] best_idx;
    logic [5:0] best_lvl;
    logic [5:0] lvl;
    logic [5:0] shift;
    found = 1'b0;
    best_idx = 6'h00;
    best_lvl = 6'h00;
    lvl = 6'h00;
    shift = 6'h00;
    for (int i = 0; i < vicb_pkg::NUM_SLOTS; i++) begin
      lvl = cfg_reg[i][vicb_pkg::LEVEL_LSB +: vicb_pkg::LEVEL_W];
      if (pend_reg[i] && (!found || lvl > best_lvl)) begin
        found = 1'b1;
        best_idx = 6'(i);
        best_lvl = lvl;
      end
    end
    valid_next = found;
    win_next = best_idx;
    level_next = best_lvl;
    nmi_next = cfg_reg[best_idx[4:0]][vicb_pkg::NMI_BIT];
    regset_next = cfg_reg[best_idx[4:0]][vicb_pkg::REGSET_LSB +: vicb_pkg::REGSET_W];
    // index times bytes per vector plus base; four shifted by size
    shift = 6'(gcfg_reg[vicb_pkg::SIZE_W-1:0]) + 6'(vicb_pkg::ENTRY_SHIFT_BASE);
    handler_next = (32'(best_idx) << shift) + base_reg;
    // chained winner passes through unchanged (ties stay local)
    if (chain_on && CHAIN_VALID && (!found || CHAIN_LEVEL > best_lvl)) begin
      valid_next = 1'b1;
      win_next = vicb_pkg::CHAIN_INDEX;
      level_next = CHAIN_LEVEL;
      nmi_next = CHAIN_NMI;
      regset_next = CHAIN_REGSET;
      handler_next = CHAIN_HANDLER;
    end
    if (!valid_next) begin
      win_next = 6'h00;
      level_next = 6'h00;
      nmi_next = 1'b0;
      regset_next = 6'h00;
      handler_next = vicb_pkg::RESET_WORD;
    end
  end

  // read mux, one cycle latency
  always_comb begin
    rdata_next = vicb_pkg::RESET_WORD;
    if (CSR_READ) begin
      if (CSR_ADDRESS <= vicb_pkg::OFS_CFG_LAST) begin
        if (present[CSR_ADDRESS[4:0]]) begin
          rdata_next[vicb_pkg::CFG_W-1:0] = cfg_reg[CSR_ADDRESS[4:0]];
        end
      end
      unique case (CSR_ADDRESS)
        vicb_pkg::OFS_RAW_STATUS: rdata_next = irq_sync_reg & present;
        vicb_pkg::OFS_SW_REQUEST: rdata_next = sw_req_reg;
        // chain bit reads back only when built
        vicb_pkg::OFS_GLOBAL_CFG: rdata_next[vicb_pkg::SIZE_W:0] = gcfg_reg;
        vicb_pkg::OFS_GLOBAL_STATUS: begin
          rdata_next[vicb_pkg::WIN_LSB +: vicb_pkg::WIN_W] = win_reg;
          rdata_next[vicb_pkg::OUTSTANDING_BIT] = valid_reg;
        end
        vicb_pkg::OFS_VEC_BASE: rdata_next = base_reg;
        vicb_pkg::OFS_HANDLER: rdata_next = handler_reg;
        // set and clear aliases and unmapped words read zero
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      sw_req_reg <= vicb_pkg::RESET_WORD;
      pend_reg <= vicb_pkg::RESET_WORD;
      gcfg_reg <= vicb_pkg::RESET_GCFG;
      base_reg <= vicb_pkg::RESET_WORD;
      rdata_reg <= vicb_pkg::RESET_WORD;
      valid_reg <= 1'b0;
      win_reg <= 6'h00;
      level_reg <= 6'h00;
      nmi_reg <= 1'b0;
      regset_reg <= 6'h00;
      handler_reg <= vicb_pkg::RESET_WORD;
      for (int i = 0; i < vicb_pkg::NUM_SLOTS; i++) begin
        cfg_reg[i] <= vicb_pkg::RESET_CFG;
      end
    end else begin
      sw_req_reg <= sw_req_next;
      pend_reg <= pend_next;
      gcfg_reg <= gcfg_next;
      base_reg <= base_next;
      rdata_reg <= rdata_next;
      valid_reg <= valid_next;
      win_reg <= win_next;
      level_reg <= level_next;
      nmi_reg <= nmi_next;
      regset_reg <= regset_next;
      handler_reg <= handler_next;
      for (int i = 0; i < vicb_pkg::NUM_SLOTS; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
    end
  end

  assign CSR_READDATA = rdata_reg;
  assign PENDING = pend_reg;
  assign OUT_VALID = valid_reg;
  assign OUT_LEVEL = level_reg;
  assign OUT_NMI = nmi_reg;
  assign OUT_REGSET = regset_reg;
  assign OUT_HANDLER = handler_reg;
endmodule

/* vicb_sva.sv */
`timescale 1ns/1ps
module vicb_chk #(
  parameter int NUM_INPUTS = 8
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [5:0] CSR_ADDRESS,
  input wire logic CSR_READ,
  input wire logic [31:0] CSR_READDATA,
  input wire logic [31:0] ENABLE,
  input wire logic [31:0] CHAIN_HANDLER,
  input wire logic [31:0] PENDING,
  input wire logic OUT_VALID,
  input wire logic [5:0] OUT_LEVEL,
  input wire logic [31:0] OUT_HANDLER
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  sequence rd_of(a);
    CSR_READ && CSR_ADDRESS == a;
  endsequence
  sequence no_local;
    PENDING == 32'h0;
  endsequence
  a_pend_gated: assert property ((PENDING & ~$past(ENABLE)) == 32'h0)
    else $error("pending without enable");
  a_absent_quiet: assert property ((PENDING >> NUM_INPUTS) == 32'h0)
    else $error("absent input pending");
  a_idle_out_zero: assert property (!OUT_VALID |-> OUT_HANDLER == 32'h0 && OUT_LEVEL == 6'h0)
    else $error("idle output not zero");
  a_pend_to_out: assert property (PENDING != 32'h0 |=> OUT_VALID)
    else $error("pending not presented");
  a_chain_pass: assert property (no_local ##1 OUT_VALID |-> OUT_HANDLER == $past(CHAIN_HANDLER))
    else $error("chain handler altered");
  a_status_read: assert property (rd_of(6'h29) |=> CSR_READDATA[30:6] == 25'h0
    && CSR_READDATA[31] == $past(OUT_VALID))
    else $error("status word wrong");
  a_handler_read: assert property (rd_of(6'h2b) |=> CSR_READDATA == $past(OUT_HANDLER))
    else $error("handler read wrong");
  a_alias_read: assert property ((rd_of(6'h26) or rd_of(6'h27)) |=> CSR_READDATA == 32'h0)
    else $error("alias read not zero");
endmodule

/* vicb_cpu.sv */
`timescale 1ns/1ps
module vicb_cpu (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [31:0] req_handler,
  output logic [31:0] taken_reg
);
  logic seen_reg;
  logic [31:0] taken_next;
  // core fetches a vector only on a fresh request, not while it stays up
  always_comb begin
    taken_next = (req_valid && !seen_reg) ? req_handler : taken_reg;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seen_reg <= 1'b0;
      taken_reg <= 32'h0;
    end else begin
      seen_reg <= req_valid;
      taken_reg <= taken_next;
    end
  end
endmodule

/* vicb_tb_top.sv */
`timescale 1ns/1ps
module vectored_irq_csr_bank_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] addr = 6'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] irq = 32'h0;
  logic [31:0] en = 32'h0;
  logic cv = 1'b0;
  logic [5:0] clev = 6'h0;
  logic [31:0] chand = 32'h0;
  logic cnmi = 1'b0;
  logic [5:0] creg = 6'h0;
  logic [31:0] rdata, pend, ohand, taken;
  logic ov;
  logic onmi;
  logic [5:0] olev;
  logic [5:0] oregs;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  vicb_top #(.NUM_INPUTS(8), .CHAIN_PRESENT(1'b1)) i_dut (.CLOCK(clk), .RESETN(rst_n),
    .CSR_ADDRESS(addr), .CSR_WRITE(wr), .CSR_READ(rd), .CSR_WRITEDATA(wdata),
    .CSR_READDATA(rdata), .IRQ(irq), .ENABLE(en), .CHAIN_VALID(cv), .CHAIN_LEVEL(clev),
    .CHAIN_NMI(cnmi), .CHAIN_REGSET(creg), .CHAIN_HANDLER(chand), .PENDING(pend),
    .OUT_VALID(ov), .OUT_LEVEL(olev), .OUT_NMI(onmi), .OUT_REGSET(oregs),
    .OUT_HANDLER(ohand));
  vicb_cpu i_cpu (.clk(clk), .rst_n(rst_n), .req_valid(ov), .req_handler(ohand),
    .taken_reg(taken));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [5:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ceiling well above the hundred or so cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 'h24; a < 'h2c; a++) rreg(6'(a), 32'h0);
    wreg(6'h03, 32'hffffffff);
    rreg(6'h03, 32'h1fff);
    wreg(6'h09, 32'hffffffff);
    rreg(6'h09, 32'h0);
    wreg(6'h28, 32'hffffffff);
    rreg(6'h28, 32'hf);
    // 16 bytes per entry, chain on
    wreg(6'h28, 32'ha);
    wreg(6'h2a, 32'h1000);
    wreg(6'h25, 32'hffffffff);
    rreg(6'h25, 32'hff);
    wreg(6'h27, 32'hfe);
    rreg(6'h25, 32'h1);
    wreg(6'h26, 32'h10);
    rreg(6'h25, 32'h11);
    chk(pend, 32'h0);
    @(posedge clk);
    en <= 32'h10;
    repeat (3) @(posedge clk);
    rreg(6'h2b, 32'h1040);
    rreg(6'h29, 32'h80000004);
    chk(pend, 32'h10);
    // level 5, non-maskable, register set 0x3e
    wreg(6'h06, 32'h1f45);
    // input 9 is absent and must stay invisible
    irq <= 32'h240;
    en <= 32'h50;
    repeat (5) @(posedge clk);
    rreg(6'h24, 32'h40);
    rreg(6'h2b, 32'h1060);
    chk(pend, 32'h50);
    chk({26'h0, olev}, 32'h5);
    chk({31'h0, onmi}, 32'h1);
    chk({26'h0, oregs}, 32'h3e);
    @(posedge clk);
    cv <= 1'b1;
    clev <= 6'h6;
    chand <= 32'h2000;
    rreg(6'h29, 32'h80000020);
    rreg(6'h2b, 32'h2000);
    wreg(6'h28, 32'h2);
    rreg(6'h2b, 32'h1060);
    irq <= 32'h0;
    wreg(6'h27, 32'hffffffff);
    repeat (5) @(posedge clk);
    rreg(6'h2b, 32'h0);
    rreg(6'h29, 32'h0);
    chk(taken, 32'h1040);
    // chain alone, no local request outstanding
    @(posedge clk);
    cnmi <= 1'b1;
    creg <= 6'h2a;
    wreg(6'h28, 32'ha);
    repeat (3) @(posedge clk);
    rreg(6'h2b, 32'h2000);
    rreg(6'h29, 32'h80000020);
    chk({26'h0, olev}, 32'h6);
    chk({31'h0, onmi}, 32'h1);
    chk({26'h0, oregs}, 32'h2a);
    chk(taken, 32'h2000);
    close_out();
  end
endmodule
bind vicb_top vicb_chk #(.NUM_INPUTS(NUM_INPUTS)) i_chk (.CLOCK(CLOCK), .RESETN(RESETN),
  .CSR_ADDRESS(CSR_ADDRESS), .CSR_READ(CSR_READ), .CSR_READDATA(CSR_READDATA),
  .ENABLE(ENABLE), .CHAIN_HANDLER(CHAIN_HANDLER), .PENDING(PENDING),
  .OUT_VALID(OUT_VALID), .OUT_LEVEL(OUT_LEVEL), .OUT_HANDLER(OUT_HANDLER));
